// [core/drive_stop_brake_supervisor.sv]
// Supervisory stop, restart, display and brake duty logic of a drive inverter.
// Assumes inputs synchronous to I_MCLK and settings held stable by the host.
`timescale 1ns/100ps
module drive_stop_brake_supervisor #(
  parameter int FREQ_W = drive_sup_pkg::FREQ_W,
  parameter int SLOT_CYCLES = drive_sup_pkg::SLOT_CYCLES,
  parameter int DELAY_TICK_CYCLES = drive_sup_pkg::DELAY_TICK_CYCLES
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  // Settings
  input wire drive_sup_pkg::settings_t I_SETTINGS,
  input wire logic I_SETTINGS_WE,
  input wire logic [7:0] I_RESTART_DELAY_TIME,
  // Operator and terminals
  input wire logic I_RUN_CMD,
  input wire logic I_STOP_KEY,
  input wire logic I_DIRECTION_COMMAND_TERMINALS,
  input wire logic I_FREE_RUN_STOP_INPUT,
  input wire logic I_BRAKE_ACTIVE,
  input wire logic I_FAULT_CLEAR,
  // Monitored quantities
  input wire logic [FREQ_W-1:0] I_OUTPUT_FREQUENCY_MONITOR,
  input wire logic [15:0] I_MOTOR_CURRENT,
  input wire logic I_DIRECTION_REV,
  input wire logic [15:0] I_PID_ACTUAL,
  input wire logic [15:0] I_DIN_STATUS,
  input wire logic [15:0] I_DOUT_STATUS,
  input wire logic I_STOPPED,
  // Outputs
  output drive_sup_pkg::settings_t O_SETTINGS,
  output drive_sup_pkg::drive_cmd_t O_DRIVE_CMD,
  output logic [FREQ_W-1:0] O_SCALED_FREQUENCY_MONITOR,
  output logic [FREQ_W-1:0] O_FREQUENCY_MONITOR_OUTPUT,
  output logic [15:0] O_REMOTE_DISPLAY,
  output logic [6:0] O_BRAKE_DUTY,
  output logic O_BRAKING_OVERLOAD_FAULT,
  output logic O_RUNNING
);
  drive_sup_pkg::settings_t cfg;
  drive_sup_pkg::run_state_t state;
  drive_sup_pkg::drive_cmd_t next_cmd;
  logic running;
  logic stop_eff;
  logic frs_prev;
  logic [31:0] tick_cnt;
  logic tick;
  logic [7:0] delay_cnt;
  logic [FREQ_W+9:0] product;
  logic [FREQ_W-1:0] scaled;
  logic [6:0] duty;
  logic over;

  function automatic logic [2:0] clamp_disp(input logic [2:0] code);
    clamp_disp = (code == 3'h0) ? drive_sup_pkg::DISP_RESET : code;
  endfunction : clamp_disp

  function automatic logic [9:0] clamp_factor(input logic [9:0] f);
    if (f < drive_sup_pkg::FACTOR_MIN) begin
      clamp_factor = drive_sup_pkg::FACTOR_MIN;
    end else if (f > drive_sup_pkg::FACTOR_MAX) begin
      clamp_factor = drive_sup_pkg::FACTOR_MAX;
    end else begin
      clamp_factor = f;
    end
  endfunction : clamp_factor

  assign running = (state != drive_sup_pkg::ST_IDLE);

  // Live settings always take effect; stop-related ones only at standstill
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      cfg.factor <= drive_sup_pkg::FACTOR_RESET;
      cfg.disp_sel <= drive_sup_pkg::DISP_RESET;
      cfg.stop_inhibit <= drive_sup_pkg::SEL_ALWAYS;
      cfg.restart_mode <= drive_sup_pkg::SEL_ALWAYS;
      cfg.duty_limit <= drive_sup_pkg::DUTY_RESET;
      cfg.stop_method <= drive_sup_pkg::SEL_ALWAYS;
    end else if (I_SETTINGS_WE) begin
      cfg.factor <= clamp_factor(I_SETTINGS.factor);
      cfg.disp_sel <= clamp_disp(I_SETTINGS.disp_sel);
      if (!running) begin
        cfg.stop_inhibit <= I_SETTINGS.stop_inhibit;
        cfg.restart_mode <= I_SETTINGS.restart_mode;
        cfg.stop_method <= I_SETTINGS.stop_method;
        if (I_SETTINGS.duty_limit <= drive_sup_pkg::DUTY_MAX) begin
          cfg.duty_limit <= I_SETTINGS.duty_limit;
        end
      end
    end
  end

  assign stop_eff = I_STOP_KEY &&
    !(cfg.stop_inhibit == drive_sup_pkg::SEL_ALT && I_DIRECTION_COMMAND_TERMINALS);

  // Restart delay counts in 100 ms ticks
  assign tick = (tick_cnt == 32'(DELAY_TICK_CYCLES - 1));

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      frs_prev <= 1'b0;
    end else begin
      frs_prev <= I_FREE_RUN_STOP_INPUT;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      state <= drive_sup_pkg::ST_IDLE;
      delay_cnt <= '0;
    end else if (I_FREE_RUN_STOP_INPUT || O_BRAKING_OVERLOAD_FAULT) begin
      state <= drive_sup_pkg::ST_COAST;
    end else begin
      case (state)
        drive_sup_pkg::ST_IDLE: begin
          if (I_RUN_CMD) begin
            state <= drive_sup_pkg::ST_RUN;
          end
        end
        drive_sup_pkg::ST_RUN: begin
          if (stop_eff) begin
            state <= (cfg.stop_method == drive_sup_pkg::SEL_ALT) ?
              drive_sup_pkg::ST_COAST : drive_sup_pkg::ST_RAMP_STOP;
          end else if (!I_RUN_CMD) begin
            state <= drive_sup_pkg::ST_RAMP_STOP;
          end
        end
        drive_sup_pkg::ST_RAMP_STOP: begin
          if (I_STOPPED) begin
            state <= drive_sup_pkg::ST_IDLE;
          end
        end
        drive_sup_pkg::ST_COAST: begin
          if (frs_prev && I_RUN_CMD) begin
            delay_cnt <= I_RESTART_DELAY_TIME;
            state <= (cfg.restart_mode == drive_sup_pkg::SEL_ALT) ?
              drive_sup_pkg::ST_RESTART_WAIT : drive_sup_pkg::ST_RUN;
          end else if (I_STOPPED) begin
            state <= drive_sup_pkg::ST_IDLE;
          end
        end
        drive_sup_pkg::ST_RESTART_WAIT: begin
          if (delay_cnt == 8'h00) begin
            state <= drive_sup_pkg::ST_RUN;
          end else if (tick) begin
            delay_cnt <= delay_cnt - 8'h01;
          end
        end
        default: state <= drive_sup_pkg::ST_IDLE;
      endcase
    end
  end

  always_comb begin
    next_cmd = '0;
    next_cmd.output_enable = (state == drive_sup_pkg::ST_RUN) ||
      (state == drive_sup_pkg::ST_RAMP_STOP);
    next_cmd.ramp_down = (state == drive_sup_pkg::ST_RAMP_STOP);
    next_cmd.restart_zero = frs_prev && !I_FREE_RUN_STOP_INPUT &&
      (cfg.restart_mode == drive_sup_pkg::SEL_ALWAYS);
    next_cmd.speed_sync = (state == drive_sup_pkg::ST_RESTART_WAIT) &&
      (delay_cnt == 8'h00);
  end

  assign product = (FREQ_W + 10)'(I_OUTPUT_FREQUENCY_MONITOR) * (FREQ_W + 10)'(cfg.factor);
  assign scaled = FREQ_W'(product / (FREQ_W + 10)'(drive_sup_pkg::FACTOR_DIV));

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      O_SCALED_FREQUENCY_MONITOR <= '0;
      O_FREQUENCY_MONITOR_OUTPUT <= '0;
    end else begin
      O_SCALED_FREQUENCY_MONITOR <= scaled;
      O_FREQUENCY_MONITOR_OUTPUT <= scaled;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      O_REMOTE_DISPLAY <= '0;
    end else begin
      case (cfg.disp_sel)
        drive_sup_pkg::DISP_FREQ: O_REMOTE_DISPLAY <= 16'(I_OUTPUT_FREQUENCY_MONITOR);
        drive_sup_pkg::DISP_CURRENT: O_REMOTE_DISPLAY <= I_MOTOR_CURRENT;
        drive_sup_pkg::DISP_DIR: O_REMOTE_DISPLAY <= {15'h0000, I_DIRECTION_REV};
        drive_sup_pkg::DISP_PID: O_REMOTE_DISPLAY <= I_PID_ACTUAL;
        drive_sup_pkg::DISP_DIN: O_REMOTE_DISPLAY <= I_DIN_STATUS;
        drive_sup_pkg::DISP_DOUT: O_REMOTE_DISPLAY <= I_DOUT_STATUS;
        drive_sup_pkg::DISP_SCALED: O_REMOTE_DISPLAY <= 16'(scaled);
        default: O_REMOTE_DISPLAY <= 16'(I_OUTPUT_FREQUENCY_MONITOR);
      endcase
    end
  end

  brake_duty_monitor #(
    .SLOT_CYCLES(SLOT_CYCLES),
    .SLOTS(drive_sup_pkg::SLOTS)
  ) u_duty (
    .I_MCLK(I_MCLK),
    .I_RSTN(I_RSTN),
    .i_brake_active(I_BRAKE_ACTIVE),
    .i_limit(cfg.duty_limit),
    .o_duty(duty),
    .o_over(over)
  );

  // Fault latches; a new overload in the clear cycle wins
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      O_BRAKING_OVERLOAD_FAULT <= 1'b0;
    end else if (over) begin
      O_BRAKING_OVERLOAD_FAULT <= 1'b1;
    end else if (I_FAULT_CLEAR) begin
      O_BRAKING_OVERLOAD_FAULT <= 1'b0;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      O_DRIVE_CMD <= '0;
      O_SETTINGS <= '0;
      O_BRAKE_DUTY <= '0;
      O_RUNNING <= 1'b0;
    end else begin
      O_DRIVE_CMD <= next_cmd;
      O_SETTINGS <= cfg;
      O_BRAKE_DUTY <= duty;
      O_RUNNING <= running;
    end
  end

  sequence s_frs_on;
    I_FREE_RUN_STOP_INPUT;
  endsequence
  sequence s_coast;
    state == drive_sup_pkg::ST_COAST ##1 !O_DRIVE_CMD.output_enable;
  endsequence

  a_frs_cuts_output: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    s_frs_on |=> s_coast) else $error("free-run-stop did not cut output");
  a_stop_inhibit: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (state == drive_sup_pkg::ST_RUN && I_STOP_KEY && I_RUN_CMD && !I_FREE_RUN_STOP_INPUT && !O_BRAKING_OVERLOAD_FAULT
     && cfg.stop_inhibit == drive_sup_pkg::SEL_ALT && I_DIRECTION_COMMAND_TERMINALS)
    |=> state == drive_sup_pkg::ST_RUN) else $error("stop key acted while inhibited");
  a_coast_stop_type: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (state == drive_sup_pkg::ST_RUN && stop_eff && cfg.stop_method == drive_sup_pkg::SEL_ALT)
    |=> ##1 !O_DRIVE_CMD.output_enable) else $error("coast stop kept output on");
  a_ramp_stop_type: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (state == drive_sup_pkg::ST_RUN && stop_eff && !I_FREE_RUN_STOP_INPUT && !O_BRAKING_OVERLOAD_FAULT
     && cfg.stop_method == drive_sup_pkg::SEL_ALWAYS)
    |=> ##1 O_DRIVE_CMD.ramp_down) else $error("ramp stop not signalled");
  a_locked_settings: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    running |=> $stable(cfg.stop_method) && $stable(cfg.restart_mode)
      && $stable(cfg.stop_inhibit) && $stable(cfg.duty_limit)) else $error("setting changed while running");
  // The release edge itself still loads reset values, so the cycle after it is skipped
  a_scaled_value: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    $past(I_RSTN) |-> O_FREQUENCY_MONITOR_OUTPUT == $past(scaled)) else $error("scaled frequency mismatch");
  a_duty_disabled: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    (cfg.duty_limit == 7'h00 && $past(cfg.duty_limit) == 7'h00) |-> !over) else $error("monitor active at zero");
  a_overload_latch: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    over |=> O_BRAKING_OVERLOAD_FAULT ##1 state == drive_sup_pkg::ST_COAST) else $error("overload not raised");
  a_restart_zero: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    ($fell(I_FREE_RUN_STOP_INPUT) && cfg.restart_mode == drive_sup_pkg::SEL_ALWAYS)
    |=> O_DRIVE_CMD.restart_zero) else $error("no zero restart");
  a_display_scaled: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    cfg.disp_sel == drive_sup_pkg::DISP_SCALED |=> O_REMOTE_DISPLAY == 16'($past(scaled)))
    else $error("display select wrong");

  // Restart after a free-run-stop release: decision edge, then run, then output on
  sequence s_frs_release;
    state == drive_sup_pkg::ST_COAST && frs_prev && !I_FREE_RUN_STOP_INPUT && I_RUN_CMD
      && !O_BRAKING_OVERLOAD_FAULT;
  endsequence
  sequence s_run_on;
    state == drive_sup_pkg::ST_RUN ##1 O_DRIVE_CMD.output_enable;
  endsequence
  sequence s_sync_due;
    state == drive_sup_pkg::ST_RESTART_WAIT && delay_cnt == 8'h00 && !I_FREE_RUN_STOP_INPUT
      && !O_BRAKING_OVERLOAD_FAULT;
  endsequence

  a_zero_restart_run: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    s_frs_release ##0 cfg.restart_mode == drive_sup_pkg::SEL_ALWAYS |=> s_run_on)
    else $error("zero restart did not run");
  a_delayed_wait: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    s_frs_release ##0 cfg.restart_mode == drive_sup_pkg::SEL_ALT |=> state == drive_sup_pkg::ST_RESTART_WAIT)
    else $error("restart delay skipped");
  a_sync_then_run: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    s_sync_due |=> O_DRIVE_CMD.speed_sync ##0 s_run_on) else $error("speed sync restart missing");
  a_wait_output_off: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    state == drive_sup_pkg::ST_RESTART_WAIT |=> !O_DRIVE_CMD.output_enable) else $error("output on during delay");
  a_fault_sticky: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    O_BRAKING_OVERLOAD_FAULT && !I_FAULT_CLEAR |=> O_BRAKING_OVERLOAD_FAULT) else $error("fault dropped");
  a_duty_limit_range: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    cfg.duty_limit <= drive_sup_pkg::DUTY_MAX) else $error("duty limit above range");
  // Clamping keeps the stored factor inside 0.1..99.9 for any written factor
  a_factor_range: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    cfg.factor >= drive_sup_pkg::FACTOR_MIN && cfg.factor <= drive_sup_pkg::FACTOR_MAX)
    else $error("factor out of range");
  a_monitor_twin: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    O_SCALED_FREQUENCY_MONITOR == O_FREQUENCY_MONITOR_OUTPUT) else $error("monitor outputs differ");
endmodule : drive_stop_brake_supervisor

// [core/drive_sup_pkg.sv]
// Constants, types and functional notes for the drive stop and brake supervisor.
// Assumes one 125 MHz clock and parameter settings presented as plain ports.
// Functional notes
// - Scaled frequency equals output frequency times factor 0.1..99.9, default 1.0, also on monitor output.
// - Stop key inhibit 00: stop key always acts; 01: ignored under terminal direction control.
// - Active free-run-stop input cuts output immediately, motor coasts.
// - Restart mode 00: restart from 0 Hz after free-run-stop release.
// - Restart mode 01: wait restart delay after release, then synchronise to motor speed.
// - Remote display code 01..07 selects frequency, current, direction, PID, inputs, outputs, scaled.
// - Factor and display select change while running; other settings only when stopped.
// - Brake duty limit is 0..100 percent of a 100 s braking window.
// - Braking longer than the limit allows raises the braking overload fault.
// - A limit of 0 percent disables duty monitoring; default is 0. The code only masks the fault; braking duty is still counted and output.
// - Stop method 00: stop key ramps down; 01: stop key cuts output, coasting.
package drive_sup_pkg;
  localparam int FREQ_W = 16;
  localparam int DISP_W = 16;
  localparam logic [9:0] FACTOR_MIN = 10'h001;
  localparam logic [9:0] FACTOR_MAX = 10'h3E7;
  localparam logic [9:0] FACTOR_RESET = 10'h00A;
  localparam logic [9:0] FACTOR_DIV = 10'h00A;
  localparam logic [1:0] SEL_ALWAYS = 2'h0;
  localparam logic [1:0] SEL_ALT = 2'h1;
  localparam logic [2:0] DISP_RESET = 3'h1;
  localparam logic [2:0] DISP_FREQ = 3'h1;
  localparam logic [2:0] DISP_CURRENT = 3'h2;
  localparam logic [2:0] DISP_DIR = 3'h3;
  localparam logic [2:0] DISP_PID = 3'h4;
  localparam logic [2:0] DISP_DIN = 3'h5;
  localparam logic [2:0] DISP_DOUT = 3'h6;
  localparam logic [2:0] DISP_SCALED = 3'h7;
  localparam logic [6:0] DUTY_MAX = 7'h64;
  localparam logic [6:0] DUTY_RESET = 7'h00;
  localparam int CLK_HZ = 125_000_000;
  localparam int WINDOW_S = 100;
  localparam int SLOT_MS = 1000;
  localparam int SLOTS = WINDOW_S * 1000 / SLOT_MS;
  localparam int SLOT_CYCLES = CLK_HZ / 1000 * SLOT_MS;
  localparam int DELAY_TICK_MS = 100;
  localparam int DELAY_TICK_CYCLES = CLK_HZ / 1000 * DELAY_TICK_MS;

  typedef enum {ST_IDLE, ST_RUN, ST_RAMP_STOP, ST_COAST, ST_RESTART_WAIT} run_state_t;

  typedef struct packed {
    logic [9:0] factor;
    logic [2:0] disp_sel;
    logic [1:0] stop_inhibit;
    logic [1:0] restart_mode;
    logic [6:0] duty_limit;
    logic [1:0] stop_method;
  } settings_t;

  typedef struct packed {
    logic output_enable;
    logic ramp_down;
    logic restart_zero;
    logic speed_sync;
  } drive_cmd_t;
endpackage : drive_sup_pkg

// [core/brake_duty_monitor.sv]
// Sliding-window braking duty monitor built from one-second slots.
// Assumes a brake-active level synchronous to the clock.
`timescale 1ns/100ps
module brake_duty_monitor #(
  parameter int SLOT_CYCLES = drive_sup_pkg::SLOT_CYCLES,
  parameter int SLOTS = drive_sup_pkg::SLOTS
) (
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic i_brake_active,
  input wire logic [6:0] i_limit,
  output logic [6:0] o_duty,
  output logic o_over
);
  // Each slot counts as braking if the brake was active at any time in it;
  // coarse, but one bit per slot keeps the window small.
  logic [31:0] tick_cnt;
  logic [SLOTS-1:0] slot_bits;
  logic [6:0] slot_idx;
  logic slot_hit;
  logic [6:0] duty;
  logic slot_end;

  assign slot_end = (tick_cnt == 32'(SLOT_CYCLES - 1));

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      tick_cnt <= '0;
    end else if (slot_end) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      slot_hit <= 1'b0;
      slot_idx <= '0;
      slot_bits <= '0;
    end else if (slot_end) begin
      slot_bits[slot_idx] <= slot_hit | i_brake_active;
      slot_hit <= 1'b0;
      slot_idx <= (slot_idx == 7'(SLOTS - 1)) ? 7'h00 : slot_idx + 7'h01;
    end else if (i_brake_active) begin
      slot_hit <= 1'b1;
    end
  end

  always_comb begin
    duty = '0;
    for (int k = 0; k < SLOTS; k++) begin
      duty = duty + 7'(slot_bits[k]);
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      o_duty <= '0;
      o_over <= 1'b0;
    end else begin
      o_duty <= duty;
      o_over <= (i_limit != 7'h00) && (duty > i_limit);
    end
  end
endmodule : brake_duty_monitor

// [tb/motor_model.sv]
// Motor stand-in for the supervisor bench: speed follows the drive commands.
// Assumes drive commands registered on the same clock as the supervisor.
`timescale 1ns/100ps
module motor_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Drive side
  input wire drive_sup_pkg::drive_cmd_t i_cmd,
  output logic o_stopped
);
  logic [7:0] speed;
  logic [1:0] div;

  // Coasting sheds speed four times slower than a ramp, so it is the longer stop
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      speed <= 8'h00;
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
      if (i_cmd.output_enable && !i_cmd.ramp_down && speed < 8'h28) speed <= speed + 8'h01;
      else if (i_cmd.output_enable && i_cmd.ramp_down && speed != 8'h00) speed <= speed - 8'h01;
      else if (!i_cmd.output_enable && speed != 8'h00 && div == 2'h0) speed <= speed - 8'h01;
    end
  end

  assign o_stopped = (speed == 8'h00);
endmodule : motor_model

// [tb/drive_stop_brake_supervisor_tb.sv]
// Self-checking bench for the drive stop and brake supervisor.
// Assumes short slot and delay tick parameters and a motor model on the drive commands.
`timescale 1ns/100ps
module drive_stop_brake_supervisor_tb;
  localparam int SLOT = 20;
  localparam int TICK = 5;
  drive_sup_pkg::settings_t s_in, s_out, s_def, s;
  drive_sup_pkg::drive_cmd_t cmd;
  logic clk, rstn, we, run, stop, term, free_run_stop_input, brk, fclr, dir, fault, running, stopped;
  logic [7:0] dly;
  logic [6:0] duty;
  logic [15:0] freq, cur, pid, din, dout, scaled, fmon, disp;
  logic [15:0] dexp [1:7];
  int num_errors, compares;

  drive_stop_brake_supervisor #(.FREQ_W(16), .SLOT_CYCLES(SLOT), .DELAY_TICK_CYCLES(TICK)) DUT (
    .I_MCLK(clk), .I_RSTN(rstn), .I_SETTINGS(s_in), .I_SETTINGS_WE(we), .I_RESTART_DELAY_TIME(dly),
    .I_RUN_CMD(run), .I_STOP_KEY(stop), .I_DIRECTION_COMMAND_TERMINALS(term), .I_FREE_RUN_STOP_INPUT(free_run_stop_input),
    .I_BRAKE_ACTIVE(brk), .I_FAULT_CLEAR(fclr), .I_OUTPUT_FREQUENCY_MONITOR(freq), .I_MOTOR_CURRENT(cur),
    .I_DIRECTION_REV(dir), .I_PID_ACTUAL(pid), .I_DIN_STATUS(din), .I_DOUT_STATUS(dout), .I_STOPPED(stopped),
    .O_SETTINGS(s_out), .O_DRIVE_CMD(cmd), .O_SCALED_FREQUENCY_MONITOR(scaled), .O_FREQUENCY_MONITOR_OUTPUT(fmon),
    .O_REMOTE_DISPLAY(disp), .O_BRAKE_DUTY(duty), .O_BRAKING_OVERLOAD_FAULT(fault), .O_RUNNING(running));

  motor_model partner (.i_clk(clk), .i_rstn(rstn), .i_cmd(cmd), .o_stopped(stopped));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  function automatic logic sig(input int k);
    case (k)
      0: return cmd.output_enable;
      1: return cmd.ramp_down;
      2: return cmd.restart_zero;
      3: return cmd.speed_sync;
      4: return running;
      default: return fault;
    endcase
  endfunction : sig

  // Bounded wait, so a missing event shows as a mismatch rather than a hang
  task automatic wait_sig(input int k, input logic v, input int maxc, input string msg);
    int i;
    i = 0;
    while (sig(k) !== v && i < maxc) begin
      cyc(1);
      i++;
    end
    check(32'(sig(k)), 32'(v), msg);
  endtask : wait_sig

  task automatic setw(input drive_sup_pkg::settings_t v);
    @(posedge clk);
    s_in <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    cyc(2);
  endtask : setw

  task automatic drv(input logic r, input logic k, input logic f);
    @(posedge clk);
    run <= r;
    stop <= k;
    free_run_stop_input <= f;
    #1;
  endtask : drv

  task automatic start();
    drv(1'b1, 1'b0, 1'b0);
    wait_sig(0, 1'b1, 6, "enable on");
  endtask : start

  task automatic halt();
    drv(1'b0, 1'b1, 1'b0);
    wait_sig(4, 1'b0, 300, "idle");
    drv(1'b0, 1'b0, 1'b0);
  endtask : halt

  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    cyc(2);
  endtask : do_reset

  // One-cycle pulses a slot apart, so each pulse marks exactly one slot
  task automatic pulse_brk(input int n);
    repeat (n) begin
      @(posedge clk);
      brk <= 1'b1;
      @(posedge clk);
      brk <= 1'b0;
      repeat (SLOT - 2) @(posedge clk);
    end
    #1;
  endtask : pulse_brk

  task automatic done(input string name);
    $display("Test %s ended at %0t", name, $time);
  endtask : done

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    summarize();
  end

  initial begin
    {rstn, we, run, stop, free_run_stop_input, brk, fclr, dly} = '0;
    {term, dir} = 2'h3;
    {freq, cur, pid, din, dout} = {16'h0064, 16'h1111, 16'h4444, 16'h5555, 16'h6666};
    s_in = '0;
    s_def = '0;
    s_def.factor = drive_sup_pkg::FACTOR_RESET;
    s_def.disp_sel = drive_sup_pkg::DISP_RESET;
    dexp = '{16'h0064, 16'h1111, 16'h0001, 16'h4444, 16'h5555, 16'h6666, 16'h00FA};
    do_reset();
    check(32'(s_out), 32'(s_def), "reset settings");
    check(32'({cmd, fault}), 32'h0, "reset outputs");
    check(32'(scaled), 32'h0064, "default factor");
    s = s_def;
    s.factor = 10'h019;
    for (int k = 1; k <= 7; k++) begin
      s.disp_sel = 3'(k);
      setw(s);
      check(32'(disp), 32'(dexp[k]), "display code");
    end
    @(posedge clk);
    freq <= 16'h0041;
    s.factor = 10'h3E7;
    setw(s);
    check({scaled, fmon}, {16'h195D, 16'h195D}, "factor 99.9");
    s.factor = 10'h001;
    setw(s);
    check({scaled, fmon}, {16'h0006, 16'h0006}, "factor 0.1");
    done("display");
    setw(s_def);
    start();
    s.factor = 10'h014;
    {s.stop_inhibit, s.restart_mode, s.duty_limit, s.stop_method} = {2'h1, 2'h1, 7'h05, 2'h1};
    setw(s);
    check(32'(s_out.factor), 32'h014, "factor while running");
    check(32'({s_out.stop_inhibit, s_out.restart_mode, s_out.duty_limit, s_out.stop_method}), 32'h0, "locked");
    drv(1'b1, 1'b1, 1'b0);
    wait_sig(1, 1'b1, 6, "ramp stop");
    check(32'(cmd.output_enable), 32'h1, "ramp keeps output");
    halt();
    s = s_def;
    s.stop_inhibit = 2'h1;
    setw(s);
    start();
    drv(1'b1, 1'b1, 1'b0);
    cyc(10);
    check(32'({running, cmd.output_enable, cmd.ramp_down}), 32'h6, "stop key ignored");
    @(posedge clk);
    term <= 1'b0;
    wait_sig(1, 1'b1, 6, "stop key acts");
    halt();
    @(posedge clk);
    term <= 1'b1;
    s = s_def;
    s.stop_method = 2'h1;
    setw(s);
    start();
    drv(1'b1, 1'b1, 1'b0);
    wait_sig(0, 1'b0, 4, "coast cut");
    check(32'(cmd.ramp_down), 32'h0, "no ramp on coast");
    halt();
    done("stop");
    setw(s_def);
    start();
    drv(1'b1, 1'b0, 1'b1);
    wait_sig(0, 1'b0, 3, "free run cut");
    check(32'(cmd.ramp_down), 32'h0, "free run no ramp");
    cyc(10);
    drv(1'b1, 1'b0, 1'b0);
    wait_sig(2, 1'b1, 5, "zero restart");
    wait_sig(0, 1'b1, 5, "restart on");
    halt();
    @(posedge clk);
    dly <= 8'h02;
    s = s_def;
    s.restart_mode = 2'h1;
    setw(s);
    start();
    drv(1'b1, 1'b0, 1'b1);
    cyc(10);
    drv(1'b1, 1'b0, 1'b0);
    repeat (TICK) begin
      check(32'({cmd.speed_sync, cmd.output_enable}), 32'h0, "restart held");
      cyc(1);
    end
    wait_sig(3, 1'b1, 4 * TICK, "speed sync");
    wait_sig(0, 1'b1, 6, "sync on");
    halt();
    done("free run");
    do_reset();
    pulse_brk(5);
    cyc(SLOT + 4);
    check(32'(fault), 32'h0, "limit 0 no fault");
    s = s_def;
    s.duty_limit = 7'h65;
    setw(s);
    check(32'(s_out.duty_limit), 32'h0, "limit over 100");
    s.duty_limit = 7'h07;
    setw(s);
    pulse_brk(2);
    cyc(SLOT + 4);
    check(32'({duty, fault}), {24'h0, 7'h07, 1'b0}, "duty at limit");
    pulse_brk(1);
    wait_sig(5, 1'b1, SLOT + 6, "overload");
    cyc(102 * SLOT);
    check(32'(duty), 32'h0, "window aged out");
    @(posedge clk);
    fclr <= 1'b1;
    @(posedge clk);
    fclr <= 1'b0;
    cyc(2);
    check(32'(fault), 32'h0, "fault cleared");
    done("brake duty");
    summarize();
  end
endmodule : drive_stop_brake_supervisor_tb
